// ### src/irask_pkg.sv
// package: register map, field layout and reset values of the ir ask modulator
package irask_pkg;
  localparam int unsigned TMR_W = 16;
  // register byte offsets
  localparam logic [7:0] ctrl_off        = 8'h00;
  localparam logic [7:0] car_period_off  = 8'h04;
  localparam logic [7:0] car_duty_off    = 8'h08;
  localparam logic [7:0] env_period_off  = 8'h0c;
  localparam logic [7:0] env_duty_off    = 8'h10;
  localparam logic [7:0] status_off      = 8'h14;
  // control field positions
  localparam int unsigned ctrl_en_bit      = 0;
  localparam int unsigned ctrl_src_lsb     = 1;
  localparam int unsigned ctrl_cascade_bit = 3;
  localparam int unsigned ctrl_swbit_bit   = 4;
  // reset values
  localparam logic [31:0]    ctrl_rst   = 32'h0000_0000;
  localparam logic [TMR_W-1:0] period_rst = 16'h0000;
  localparam logic [TMR_W-1:0] duty_rst   = 16'h0000;
  // axi responses
  localparam logic [1:0] resp_okay   = 2'b00;
  localparam logic [1:0] resp_slverr = 2'b10;
  // envelope source selection
  typedef enum logic [1:0] {
    irask_src_timer,
    irask_src_serial,
    irask_src_soft
  } irask_src_t;
  // compare pair carried together
  typedef struct packed {
    logic [TMR_W-1:0] period;
    logic [TMR_W-1:0] duty;
  } irask_cmp_t;
endpackage : irask_pkg

// ### src/irask_top.sv
// file: ir ask modulator with two compare timers and axi4-lite registers
//
// Summary of operation
// (R1) envelope high passes carrier to output; envelope low forces output low.
// (R2) envelope chosen from envelope timer, serial port zero transmit, or software bit.
// (R3) envelope timer may count carrier periods instead of system clocks.
// (R4) modulated output is AND of carrier and envelope compare outputs.
// (R5) software programs carrier compares once for a 38 kHz carrier.
// (R6) software reloads envelope compares per bit to encode pulse and space.
// (R7) new envelope compares apply only at the next envelope period boundary.
//
// The AXI4-Lite register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
module irask_top #(
  parameter int unsigned TMR_W = irask_pkg::TMR_W
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        serial_tx_in,
  output logic             ir_mod_out
);
  // register state
  logic [31:0]          ctrl_r;
  irask_pkg::irask_cmp_t car_r;
  irask_pkg::irask_cmp_t env_r;
  irask_pkg::irask_cmp_t env_act_r;
  logic [TMR_W-1:0]     car_cnt_r;
  logic [TMR_W-1:0]     env_cnt_r;
  logic                 car_out_r;
  logic                 env_out_r;
  logic                 car_tick_r;
  logic                 env_pend_r;
  logic                 ser_s1_r;
  logic                 ser_s2_r;
  logic                 aw_hold_r;
  logic                 w_hold_r;
  logic [7:0]           aw_addr_r;
  logic [31:0]          w_data_r;
  logic [3:0]           w_strb_r;
  logic                 enable;
  logic                 cascade;
  irask_pkg::irask_src_t src;
  logic                 envelope;
  logic                 env_step;
  logic                 env_wrap;
  logic                 do_write;

  assign enable  = ctrl_r[irask_pkg::ctrl_en_bit];
  assign cascade = ctrl_r[irask_pkg::ctrl_cascade_bit];
  assign src     = irask_pkg::irask_src_t'(ctrl_r[irask_pkg::ctrl_src_lsb +: 2]);

  // two-stage sync of serial transmit line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ser_s1_r <= 1'b1;
      ser_s2_r <= 1'b1;
    end else begin
      ser_s1_r <= serial_tx_in;
      ser_s2_r <= ser_s1_r;
    end
  end

  // axi write channel capture, address and data in either order
  assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= irask_pkg::resp_okay;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_r == irask_pkg::ctrl_off || aw_addr_r == irask_pkg::car_period_off ||
            aw_addr_r == irask_pkg::car_duty_off || aw_addr_r == irask_pkg::env_period_off ||
            aw_addr_r == irask_pkg::env_duty_off || aw_addr_r == irask_pkg::status_off) begin
          s_axi_bresp <= irask_pkg::resp_okay;
        end else begin
          s_axi_bresp <= irask_pkg::resp_slverr;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // byte-lane merge into writable registers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        res[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return res;
  endfunction : merge

  // control, carrier compare and shadow envelope compare registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r     <= irask_pkg::ctrl_rst;
      car_r      <= '{period: irask_pkg::period_rst, duty: irask_pkg::duty_rst};
      env_r      <= '{period: irask_pkg::period_rst, duty: irask_pkg::duty_rst};
      env_pend_r <= 1'b0;
    end else begin
      if (env_wrap) begin
        env_pend_r <= 1'b0;
      end
      if (do_write) begin
        if (aw_addr_r == irask_pkg::ctrl_off) begin
          ctrl_r <= merge(ctrl_r, w_data_r, w_strb_r) & 32'h0000_001f;
        end else if (aw_addr_r == irask_pkg::car_period_off) begin
          car_r.period <= TMR_W'(merge(32'(car_r.period), w_data_r, w_strb_r)); // R5
        end else if (aw_addr_r == irask_pkg::car_duty_off) begin
          car_r.duty <= TMR_W'(merge(32'(car_r.duty), w_data_r, w_strb_r)); // R5
        end else if (aw_addr_r == irask_pkg::env_period_off) begin
          env_r.period <= TMR_W'(merge(32'(env_r.period), w_data_r, w_strb_r)); // R6
          env_pend_r   <= 1'b1; // R7
        end else if (aw_addr_r == irask_pkg::env_duty_off) begin
          env_r.duty <= TMR_W'(merge(32'(env_r.duty), w_data_r, w_strb_r)); // R6
          env_pend_r <= 1'b1; // R7
        end
      end
    end
  end

  // axi read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= irask_pkg::resp_okay;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= irask_pkg::resp_okay;
        if (s_axi_araddr == irask_pkg::ctrl_off) begin
          s_axi_rdata <= ctrl_r;
        end else if (s_axi_araddr == irask_pkg::car_period_off) begin
          s_axi_rdata <= 32'(car_r.period);
        end else if (s_axi_araddr == irask_pkg::car_duty_off) begin
          s_axi_rdata <= 32'(car_r.duty);
        end else if (s_axi_araddr == irask_pkg::env_period_off) begin
          s_axi_rdata <= 32'(env_r.period);
        end else if (s_axi_araddr == irask_pkg::env_duty_off) begin
          s_axi_rdata <= 32'(env_r.duty);
        end else if (s_axi_araddr == irask_pkg::status_off) begin
          s_axi_rdata <= {27'h0, env_pend_r, envelope, env_out_r, car_out_r, ir_mod_out};
        end else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= irask_pkg::resp_slverr;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // carrier timer: up mode, high while count below duty
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      car_cnt_r  <= '0;
      car_out_r  <= 1'b0;
      car_tick_r <= 1'b0;
    end else begin
      car_tick_r <= (car_cnt_r >= car_r.period);
      car_cnt_r  <= (car_cnt_r >= car_r.period) ? '0 : car_cnt_r + 1'b1;
      car_out_r  <= (car_cnt_r >= car_r.period) ? (car_r.duty != '0) : (car_cnt_r + 1'b1 < car_r.duty);
    end
  end

  // envelope timer, clocked by carrier periods when cascaded
  assign env_step = cascade ? car_tick_r : 1'b1; // R3
  assign env_wrap = enable && env_step && (env_cnt_r >= env_act_r.period);
  always_ff @(posedge aclk) begin
    if (!aresetn || !enable) begin
      env_cnt_r <= '0;
      env_out_r <= 1'b0;
      env_act_r <= '{period: irask_pkg::period_rst, duty: irask_pkg::duty_rst};
    end else if (env_step) begin
      if (env_wrap) begin
        env_cnt_r <= '0;
        env_act_r <= env_r; // R7
        env_out_r <= (env_r.duty != '0);
      end else begin
        env_cnt_r <= env_cnt_r + 1'b1;
        env_out_r <= (env_cnt_r + 1'b1 < env_act_r.duty);
      end
    end
  end

  // envelope source select
  always_comb begin
    case (src)
      irask_pkg::irask_src_timer:  envelope = env_out_r; // R2
      irask_pkg::irask_src_serial: envelope = ser_s2_r; // R2
      irask_pkg::irask_src_soft:   envelope = ctrl_r[irask_pkg::ctrl_swbit_bit]; // R2
      default:                     envelope = 1'b0;
    endcase
  end

  // gated output: carrier when envelope high, low otherwise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ir_mod_out <= 1'b0;
    end else begin
      ir_mod_out <= enable && car_out_r && envelope; // R1 R4
    end
  end
endmodule : irask_top

// ### tb/irask_led_model.sv
// partner model: ir led switch that counts its on cycles
`timescale 1ns/1ps
module irask_led_model (
  input wire logic    aclk,
  input wire logic    drive,
  output int unsigned on_cycles
);
  // led current flows while drive is high; an unknown level before reset counts as dark
  initial on_cycles = 0;
  always @(posedge aclk) begin
    if (drive) begin
      on_cycles <= on_cycles + 32'h0000_0001;
    end
  end
endmodule : irask_led_model

// ### tb/irask_properties.sv
// checker: port-level assertions of the ir ask modulator
`timescale 1ns/1ps
module irask_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        serial_tx_in,
  input wire logic        ir_mod_out
);
  logic [7:0] wa_r;
  logic [4:0] wd_r;
  logic [4:0] ctl_r;
  logic       wip;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // shadow of the control word, committed at the write answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wa_r <= 8'h00;
      wd_r <= 5'h00;
      ctl_r <= 5'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) wa_r <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) wd_r <= s_axi_wdata[4:0];
      if (s_axi_bvalid && s_axi_bready && wa_r == irask_pkg::ctrl_off) ctl_r <= wd_r;
    end
  end
  // shadow is trusted only with no write under way
  assign wip = s_axi_awvalid | s_axi_wvalid | s_axi_bvalid;
  sequence seq_quiet(c);
    (!wip && c) [*2];
  endsequence
  AST_DISABLED_LOW: assert property (seq_quiet(!ctl_r[0]) |-> !ir_mod_out) else $error("on while off");
  AST_SOFT_LOW: assert property (seq_quiet(ctl_r[2:1] == 2'h2 && !ctl_r[4]) |-> !ir_mod_out)
    else $error("soft bit low leaks");
  AST_SRC3_LOW: assert property (seq_quiet(ctl_r[2:1] == 2'h3) |-> !ir_mod_out)
    else $error("unused source leaks");
  AST_SERIAL_LOW: assert property ((!wip && ctl_r[2:1] == 2'h1 && !serial_tx_in) [*5] |-> !ir_mod_out)
    else $error("serial low leaks");
  // both halves held one cycle after the handshake, answer raised one cycle later
  AST_WRITE_ANSWER: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |=> ##1 s_axi_bvalid) else $error("no write answer");
endmodule : irask_properties

bind irask_top irask_properties u_irask_properties (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .serial_tx_in(serial_tx_in),
  .ir_mod_out(ir_mod_out));

// ### tb/test_ir_ask_modulation_logic.sv
// testbench: register-driven scenarios for the ir ask modulator
`timescale 1ns/1ps
module test_ir_ask_modulation_logic;
  // envelope duty of 15 of 20 gives 9 lit of 20 clocks free-running but 3 of 4 carrier periods cascaded
  localparam logic [31:0] CP = 32'h9, CD = 32'h5, EP = 32'h13, ED = 32'hf;
  localparam int unsigned HI = 400 / (CP + 1) * CD;
  logic        aclk = 1'b0, aresetn = 1'b0, ser = 1'b1;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rdata, d;
  logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  logic        awr, wr_r, bv, arr, rv, ir;
  logic [1:0]  bresp, rresp, r;
  int unsigned on_c, c0, miscompares = 0, checked = 0;
  logic [4:0]  m_ctl [8] = '{5'h15, 5'h05, 5'h07, 5'h03, 5'h03, 5'h01, 5'h09, 5'h00};
  logic [7:0]  m_ser = 8'hef;
  int unsigned m_exp [8] = '{HI, 0, 0, HI, 0, HI / 10 * 9, HI / 4 * 3, 0};
  // 200 MHz clock
  always #2.5 aclk = ~aclk;
  irask_top u_irask_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr_r),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
    .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rrdy),
    .serial_tx_in(ser), .ir_mod_out(ir));
  irask_led_model u_irask_led_model (.aclk(aclk), .drive(ir), .on_cycles(on_c));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    awa <= a;
    wd <= v;
    awv <= 1'b1;
    wv <= 1'b1;
    brdy <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (awr) awv <= 1'b0;
      if (wr_r) wv <= 1'b0;
      if (bv) begin
        r = bresp;
        done = 1'b1;
      end
    end
    brdy <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic done;
    done = 1'b0;
    @(posedge aclk);
    ara <= a;
    arv <= 1'b1;
    rrdy <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (arr) arv <= 1'b0;
      if (rv) begin
        d = rdata;
        r = rresp;
        done = 1'b1;
      end
    end
    rrdy <= 1'b0;
  endtask : rd
  task automatic tally_and_finish();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    tally_and_finish();
  end
  // reset, register access, every envelope source, deferred compare update
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(irask_pkg::ctrl_off);
    chk(d, irask_pkg::ctrl_rst);
    rd(8'h18);
    chk(d, 32'h0);
    chk(32'(r), 32'(irask_pkg::resp_slverr));
    wr(8'h18, 32'hffff);
    chk(32'(r), 32'(irask_pkg::resp_slverr));
    wr(irask_pkg::car_period_off, CP);
    wr(irask_pkg::car_duty_off, CD);
    wr(irask_pkg::env_period_off, EP);
    wr(irask_pkg::env_duty_off, ED);
    rd(irask_pkg::car_period_off);
    chk(d, CP);
    for (int i = 0; i < 8; i++) begin
      ser <= m_ser[i];
      wr(irask_pkg::ctrl_off, 32'h0);
      wr(irask_pkg::ctrl_off, 32'(m_ctl[i]));
      repeat (40) @(posedge aclk);
      c0 = on_c;
      repeat (400) @(posedge aclk);
      chk(on_c - c0, m_exp[i]);
    end
    wr(irask_pkg::env_period_off, 32'h3e7);
    wr(irask_pkg::ctrl_off, 32'h1);
    wr(irask_pkg::env_duty_off, 32'h1f4);
    rd(irask_pkg::status_off);
    chk(32'(d[4]), 32'h1);
    repeat (1100) @(posedge aclk);
    rd(irask_pkg::status_off);
    chk(32'(d[4]), 32'h0);
    tally_and_finish();
  end
endmodule : test_ir_ask_modulation_logic
